// File: bench/chip_mem_model.sv
// shared chip memory and odd-cycle arbiter facing the coprocessor
`timescale 1ns/100ps
module chip_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire copper_pkg::mem_req_t mem,
    input wire logic stall,
    output logic cycle_odd,
    output logic mem_gnt,
    output logic [15:0] mem_rdata
);
    import copper_pkg::*;
    logic [15:0] words [0:255]; // word store, loaded by the bench
    logic [15:0] last_q; // last word handed out
    // even and odd memory slots alternate every clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycle_odd <= 1'b0;
        end else begin
            cycle_odd <= ~cycle_odd;
        end
    end
    // coprocessor outranks processor and blitter, so only a forced stall holds it off
    assign mem_gnt = mem.req & cycle_odd & ~stall;
    // data is valid with the grant only; otherwise a stale word turned over
    assign mem_rdata = mem_gnt ? words[mem.addr[8:1]] : ~last_q;
    // remember the word so the idle bus never repeats it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_q <= 16'h5a5a;
        end else if (mem_gnt) begin
            last_q <= mem_rdata;
        end
    end
endmodule

// File: bench/test_copper_core.sv
// self-checking bench for the display list coprocessor
`timescale 1ns/100ps
module test_copper_core;
    import copper_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cycle_odd, mem_gnt;
    logic [15:0] mem_rdata;
    mem_req_t mem;
    beam_t beam = 16'h0;
    logic vblank_start = 1'b0;
    logic blit_busy = 1'b0;
    logic stall = 1'b0; // holds the arbiter off
    reg_wr_t reg_wr;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0; // clock count for spacing checks
    logic [18:0] fq [$]; // granted fetch addresses
    int gq [$]; // cycle of each grant
    logic [24:0] wq [$]; // register writes, {addr, data}
    logic [31:0] rdv;
    logic errv;

    // 25 MHz clock
    always #20 clk = ~clk;

    copper_core copper_core_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_odd(cycle_odd), .mem(mem), .mem_gnt(mem_gnt),
        .mem_rdata(mem_rdata), .beam(beam), .vblank_start(vblank_start),
        .blit_busy(blit_busy), .reg_wr(reg_wr));
    chip_mem_model chip_mem_model_inst (.clk(clk), .rst_n(rst_n), .mem(mem), .stall(stall),
        .cycle_odd(cycle_odd), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));

    // record grants and register writes; flag any even-slot request or low write
    always @(posedge clk) begin
        cyc++;
        if (rst_n) begin
            if (mem.req === 1'b1 && cycle_odd !== 1'b1) chk(32'h1, 32'h0);
            if (mem.req === 1'b1 && mem_gnt === 1'b1) begin
                fq.push_back(mem.addr);
                gq.push_back(cyc);
            end
            if (reg_wr.strobe === 1'b1) begin
                wq.push_back({reg_wr.addr, reg_wr.data});
                if (reg_wr.addr < 9'h010) chk(32'h1, 32'h0);
            end
        end
    end

    // one comparison, counted; a mismatch is reported at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // single closing point of the run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // apb transfer; starts one edge late so a release never meets a new setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0, rdv, errv);
        chk(rdv, exp);
        chk({31'h0, errv}, {31'h0, experr});
    endtask

    // load one two-word instruction at a word index
    task automatic put(input logic [7:0] i, input logic [15:0] a, input logic [15:0] b);
        chip_mem_model_inst.words[i] = a;
        chip_mem_model_inst.words[i + 8'h01] = b;
    endtask

    // point the list, enable, and restart it with a frame pulse
    task automatic start(input logic [18:0] loc, input logic dng);
        wr(OFS_LIST, {13'h0, loc});
        wr(OFS_CONTROL, {30'h0, dng, 1'b1});
        @(posedge clk);
        vblank_start <= 1'b1;
        @(posedge clk);
        vblank_start <= 1'b0;
        fq.delete();
        gq.delete();
        wq.delete();
    endtask

    // bounded wait for n writes, then a margin so extra writes would show
    task automatic settle(input int n);
        for (int i = 0; i < 300 && wq.size() < n; i++) @(posedge clk);
        repeat (12) @(posedge clk);
    endtask

    // reset values, unmapped access, forced-even list, read-only pc
    task automatic t_regs();
        rd_chk(OFS_CONTROL, 32'h0, 1'b0);
        rd_chk(OFS_LIST, 32'h0, 1'b0);
        rd_chk(OFS_STATUS, 32'h2, 1'b0);
        rd_chk(OFS_PC, 32'h0, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        wr(OFS_LIST, 32'h00101);
        rd_chk(OFS_LIST, 32'h00100, 1'b0);
        wr(OFS_PC, 32'h00042);
        rd_chk(OFS_PC, 32'h0, 1'b0);
        $display("register test done");
    endtask

    // two moves around a refused one, prompt or behind a stalled arbiter
    task automatic t_move(input logic slow);
        put(8'h20, 16'h0180, 16'h1234);
        put(8'h22, 16'h0012, 16'hbeef);
        put(8'h24, 16'h0040, 16'h00a5);
        put(8'h26, 16'hffff, 16'hfffe);
        stall <= slow;
        start(19'h00040, 1'b0);
        repeat (20) @(posedge clk);
        if (slow) chk(fq.size(), 0);
        stall <= 1'b0;
        settle(2);
        chk(wq.size(), 2);
        chk(wq[0], {9'h180, 16'h1234});
        chk(wq[1], {9'h040, 16'h00a5});
        chk(fq.size(), 8);
        for (int i = 0; i < 8; i++) chk(fq[i], 19'h00040 + 19'(2 * i));
        chk(gq[2] - gq[0], 4);
        rd_chk(OFS_STATUS, 32'h11, 1'b0);
        wr(OFS_STATUS, 32'h1);
        rd_chk(OFS_STATUS, 32'h10, 1'b0);
        $display("move test done");
    endtask

    // danger bit opens $10..$1f but never below $10
    task automatic t_danger();
        put(8'h40, 16'h0012, 16'h5555);
        put(8'h42, 16'h000e, 16'h6666);
        put(8'h44, 16'hffff, 16'hfffe);
        start(19'h00080, 1'b1);
        settle(1);
        chk(wq.size(), 1);
        chk(wq[0], {9'h012, 16'h5555});
        rd_chk(OFS_STATUS, 32'h11, 1'b0);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_CONTROL, 32'h1);
        $display("danger test done");
    endtask

    // waits: bus stays free, masked compare, wake cycle, blitter hold
    task automatic t_wait();
        put(8'h60, 16'h1001, 16'hff00);
        put(8'h62, 16'h0180, 16'h0777);
        put(8'h64, 16'h2001, 16'h7f00);
        put(8'h66, 16'h0182, 16'h0888);
        put(8'h68, 16'hffff, 16'hfffe);
        beam <= {8'h0f, 8'hff};
        blit_busy <= 1'b1;
        start(19'h000c0, 1'b0);
        repeat (30) @(posedge clk);
        chk(fq.size(), 2);
        chk(wq.size(), 0);
        beam <= {8'h10, 8'h00};
        settle(1);
        chk(wq[0], {9'h180, 16'h0777});
        chk(gq[3] - gq[2], 2);
        chk(fq.size(), 7);
        beam <= {8'h20, 8'h00};
        repeat (30) @(posedge clk);
        chk(wq.size(), 1);
        blit_busy <= 1'b0;
        settle(2);
        chk(wq[1], {9'h182, 16'h0888});
        chk(fq.size(), 12);
        $display("wait test done");
    endtask

    // skip bypasses the next move only when the beam has arrived
    task automatic t_skip();
        put(8'h80, 16'h1001, 16'hff01);
        put(8'h82, 16'h0180, 16'h0001);
        put(8'h84, 16'h0182, 16'h0002);
        put(8'h86, 16'hffff, 16'hfffe);
        for (int k = 0; k < 2; k++) begin
            beam <= {(k == 0) ? 8'h10 : 8'h0f, 8'h00};
            start(19'h00100, 1'b0);
            settle(1 + k);
            chk(wq.size(), 1 + k);
            chk(wq[wq.size() - 1], {9'h182, 16'h0002});
            chk(fq[2], (k == 0) ? 19'h00108 : 19'h00104);
        end
        $display("skip test done");
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_move(1'b0);
        t_move(1'b1);
        t_danger();
        t_wait();
        t_skip();
        end_sim();
    end

    // the tests need a few hundred cycles; twenty thousand means a hang
    initial begin
        #800000;
        n_fail++;
        end_sim();
    end
endmodule

// File: rtl/beam_compare.sv
// masked beam position compare shared by wait and skip
`timescale 1ns/100ps
module beam_compare (
    input wire copper_pkg::beam_t beam,
    input wire logic [15:0] first_word,
    input wire logic [15:0] second_word,
    output logic reached
);
    import copper_pkg::*;
    // vertical msb has no enable bit, so it always takes part
    wire [14:0] pos = {beam.v, beam.h[7:1]};
    wire [14:0] tgt = {first_word[15:8], first_word[7:1]};
    wire [14:0] mask = {1'b1, second_word[14:8], second_word[7:1]};
    // equal or greater counts as reached; the beam lsb is never compared
    assign reached = (pos & mask) >= (tgt & mask);
endmodule

// File: rtl/copper_apb_regs.sv
// apb slave holding control, list location and status registers
`timescale 1ns/100ps
module copper_apb_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic run,
    output logic danger,
    output logic [copper_pkg::ADDR_W-1:0] list_loc,
    input wire logic [4:0] state_code,
    input wire logic [copper_pkg::ADDR_W-1:0] pc,
    input wire logic blocked_set
);
    import copper_pkg::*;
    logic [1:0] ctrl_q;                     // run and danger
    logic [ADDR_W-1:0] list_q;              // first_list_location
    logic blocked_q;                        // sticky refused-move flag
    logic [31:0] prdata_q;                  // read data captured at setup
    // address decode
    wire hit_ctrl = paddr == OFS_CONTROL;
    wire hit_list = paddr == OFS_LIST;
    wire hit_stat = paddr == OFS_STATUS;
    wire hit_pc = paddr == OFS_PC;
    wire hit = hit_ctrl | hit_list | hit_stat | hit_pc;
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite & hit;
    wire clr_blocked = wr & hit_stat & pwdata[STAT_BLOCKED_BIT];
    // read mux, sampled in the setup cycle so prdata comes from a flop
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
        hit_list ? {13'h0, list_q} :
        hit_stat ? {26'h0, state_code, blocked_q} :
        hit_pc ? {13'h0, pc} : 32'h0;

    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_q;
    assign run = ctrl_q[CTRL_RUN_BIT];
    assign danger = ctrl_q[CTRL_DANGER_BIT];
    assign list_loc = list_q;

    // register writes; list location is kept word aligned
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            list_q <= LIST_RESET;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (hit_list) begin
                list_q <= {pwdata[ADDR_W-1:1], 1'b0};
            end
        end
    end

    // sticky flag: a new refusal wins over a write-one clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blocked_q <= 1'b0;
        end else if (blocked_set) begin
            blocked_q <= 1'b1;
        end else if (clr_blocked) begin
            blocked_q <= 1'b0;
        end
    end

    // read data capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end
endmodule

// File: rtl/copper_core.sv
// display list coprocessor: fetch, decode and execute wait, move and skip
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps

// Overview of operation
// - fetches every instruction by its own dma reads
// - waiting compares beam directly, no bus requests
// - after wait, steals cycles to continue transfers
// - requests the bus only in odd cycles
// - fetch addresses stay within low 512K bytes
// - exactly three operations: wait, move, skip
// - wait holds until beam reaches target position
// - move writes immediate data to chip register
// - skip bypasses next instruction if beam passed
// - two 16-bit words per instruction, both fetched
// - move and skip take two bus cycles
// - wait takes three bus cycles, one wakes
// - writes only registers, never memory
// - move: bit 0 clear, bits 8-1 address
// - wait word layout with position and enables
// - moves below $10 never, $10-$1f need danger
// - vertical blank reloads pc from first list
module copper_core (
    input wire logic clk,
    input wire logic rst_n,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shared memory port, one clk per memory cycle
    input wire logic cycle_odd,
    output copper_pkg::mem_req_t mem,
    input wire logic mem_gnt,
    input wire logic [15:0] mem_rdata,
    // beam counters and frame timing
    input wire copper_pkg::beam_t beam,
    input wire logic vblank_start,
    input wire logic blit_busy,
    // chip register write port
    output copper_pkg::reg_wr_t reg_wr
);
    import copper_pkg::*;

    seq_state_t state_q, state_d;          // sequencer state
    logic [ADDR_W-1:0] pc_q, pc_d;          // program counter, byte address
    logic [15:0] first_instruction_word_q;  // latched first word
    logic [15:0] second_instruction_word_q; // latched second word
    reg_wr_t reg_wr_q, reg_wr_d;            // registered write strobe
    logic blocked_d;                        // refused move, one-cycle pulse
    logic run;                              // list execution enabled
    logic danger;                           // low register window open
    logic [ADDR_W-1:0] first_list_location; // restart address
    logic reached;                          // beam at or past target

    // register block over apb
    copper_apb_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .run(run),
        .danger(danger),
        .list_loc(first_list_location),
        .state_code(state_q),
        .pc(pc_q),
        .blocked_set(blocked_d)
    );

    // second word source: live bus data while it arrives, latched after
    wire in_fetch2 = state_q == ST_FETCH2;
    wire [15:0] second_word = in_fetch2 ? mem_rdata : second_instruction_word_q;

    // one compare serves both wait and skip
    beam_compare u_cmp (
        .beam(beam),
        .first_word(first_instruction_word_q),
        .second_word(second_word),
        .reached(reached)
    );

    // decode of the latched first word and arriving second word
    wire is_move = ~first_instruction_word_q[KIND_BIT];
    wire is_skip = first_instruction_word_q[KIND_BIT] & second_word[KIND_BIT];
    wire [8:0] destination_register_word_address =
        {first_instruction_word_q[8:1], 1'b0};
    // blitter-finished-disable clear means also wait for the blitter
    wire blit_ok = second_instruction_word_q[BFD_BIT] | ~blit_busy;
    wire wait_done = reached & blit_ok;
    // low registers are protected; danger opens only $10..$1f
    wire move_ok = (destination_register_word_address >= REG_SAFE_MIN) |
        (danger & (destination_register_word_address >= REG_DANGER_MIN));

    // bus need: fetch both words and one wake cycle after a wait
    wire needs_bus = (state_q == ST_FETCH1) | in_fetch2 | (state_q == ST_WAKE);
    // only odd cycles are asked for; nothing while waiting
    assign mem.req = needs_bus & cycle_odd;
    // pc is 19 bits wide so fetches cannot leave the low 512K
    assign mem.addr = pc_q;
    // arbiter grants the odd cycle ahead of processor and blitter
    wire took = mem.req & mem_gnt;
    // only a register write port exists, there is no memory write path
    assign reg_wr = reg_wr_q;

    // timing, one clk per memory cycle and only odd slots used:
    //   move or skip: first word in one odd slot, second word in the next
    //   the register write leaves a flop one cycle after the second word
    //   wait: two fetch slots, then off the bus until the beam arrives
    //   the wake slot is a third odd-slot read whose data is dropped,
    //   so a wait costs six cycle times before the next fetch starts
    //   vblank_start restarts the list from any state, mid-wait included
    //   clearing run parks the sequencer in halt until the next frame start
    // a list location written mid-frame is used only at the next restart

    // next state and pc; stopping beats frame restart beats execution
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        reg_wr_d = '0;
        blocked_d = 1'b0;
        if (!run) begin
            state_d = ST_HALT;
        end else if (vblank_start) begin
            // restart whatever is in flight
            state_d = ST_FETCH1;
            pc_d = first_list_location;
        end else begin
            unique case (state_q)
                ST_HALT: begin
                    // idle until the next frame start
                    state_d = ST_HALT;
                end
                ST_FETCH1: begin
                    if (took) begin
                        pc_d = pc_q + PC_WORD;
                        state_d = ST_FETCH2;
                    end
                end
                ST_FETCH2: begin
                    if (took) begin
                        // second word of the pair completes the instruction
                        pc_d = pc_q + PC_WORD;
                        state_d = ST_FETCH1;
                        if (is_move) begin
                            // move ends here: two bus cycles in all
                            reg_wr_d.strobe = move_ok;
                            reg_wr_d.addr = destination_register_word_address;
                            reg_wr_d.data = mem_rdata;
                            blocked_d = ~move_ok;
                        end else if (is_skip) begin
                            // beam already there: jump over the next pair
                            if (reached) begin
                                pc_d = pc_q + PC_SKIP;
                            end
                        end else begin
                            state_d = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // off the bus, watching the beam counters
                    if (wait_done) begin
                        state_d = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // third bus cycle of a wait; its data is discarded
                    if (took) begin
                        state_d = ST_FETCH1;
                    end
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_HALT;
            pc_q <= LIST_RESET;
            reg_wr_q <= '0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            reg_wr_q <= reg_wr_d;
        end
    end

    // instruction word latches
    // only granted words are latched; a refused slot leaves both alone
    // the first word stays put through a wait so the compare still sees it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_instruction_word_q <= 16'h0000;
            second_instruction_word_q <= 16'h0000;
        end else if (took && state_q == ST_FETCH1) begin
            first_instruction_word_q <= mem_rdata;
        end else if (took && in_fetch2) begin
            second_instruction_word_q <= mem_rdata;
        end
    end

    // checks on the sequencer
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // every property runs on clk and rests while rst_n is low
    chk_odd_only_req: assert property (mem.req |-> cycle_odd)
        else $error("bus requested in an even cycle");

    chk_wait_off_bus: assert property (state_q == ST_WAIT |-> !mem.req)
        else $error("bus requested while waiting");

    chk_move_write_data: assert property (
        run && !vblank_start && took && in_fetch2 && is_move && move_ok
        |=> reg_wr.strobe && reg_wr.data == $past(mem_rdata))
        else $error("move did not write its data");

    chk_low_reg_guard: assert property (
        reg_wr.strobe |-> reg_wr.addr >= REG_DANGER_MIN &&
        (reg_wr.addr >= REG_SAFE_MIN || $past(danger)))
        else $error("move reached a protected register");

    chk_frame_reload: assert property (
        run && vblank_start |=> pc_q == $past(first_list_location) && state_q == ST_FETCH1)
        else $error("frame start did not reload pc");

    chk_fetch_step: assert property (
        run && !vblank_start && took && state_q == ST_FETCH1
        |=> pc_q == $past(pc_q) + PC_WORD && state_q == ST_FETCH2)
        else $error("first fetch did not advance pc");

    chk_skip_step: assert property (
        run && !vblank_start && took && in_fetch2 && is_skip && reached
        |=> pc_q == $past(pc_q) + PC_SKIP)
        else $error("skip did not bypass next instruction");

    chk_wait_wake: assert property (
        run && !vblank_start && state_q == ST_WAIT && wait_done |=> state_q == ST_WAKE)
        else $error("satisfied wait did not wake");

    chk_wake_then_fetch: assert property (
        run && !vblank_start && state_q == ST_WAKE && took |=> state_q == ST_FETCH1)
        else $error("wake cycle did not resume fetch");

    // an even pc keeps each word on its own aligned location
    chk_fetch_even: assert property (mem.req |-> !mem.addr[0])
        else $error("fetch address not word aligned");

    // no fetch without an instruction to finish
    chk_req_needs_work: assert property (
        mem.req |-> state_q != ST_WAIT && state_q != ST_HALT)
        else $error("bus requested with no fetch pending");

    // move and skip hand the bus back after their second word
    chk_pair_ends: assert property (
        run && !vblank_start && took && in_fetch2 && (is_move || is_skip)
        |=> state_q == ST_FETCH1)
        else $error("two-word operation did not end");

    chk_wait_decode: assert property (
        run && !vblank_start && took && in_fetch2 && !is_move && !is_skip
        |=> state_q == ST_WAIT)
        else $error("wait word pair not decoded as wait");

    chk_wait_holds: assert property (
        run && !vblank_start && state_q == ST_WAIT && !wait_done
        |=> state_q == ST_WAIT)
        else $error("wait ended before its position");

    // the wake read is thrown away, so it must not move the pc
    chk_wake_keeps_pc: assert property (
        run && !vblank_start && state_q == ST_WAKE |=> pc_q == $past(pc_q))
        else $error("wake cycle moved the pc");

    chk_skip_missed: assert property (
        run && !vblank_start && took && in_fetch2 && is_skip && !reached
        |=> pc_q == $past(pc_q) + PC_WORD)
        else $error("skip taken before the beam arrived");

    chk_skip_no_write: assert property (
        took && in_fetch2 && is_skip |=> !reg_wr.strobe)
        else $error("skip produced a register write");

    chk_refused_silent: assert property (
        took && in_fetch2 && is_move && !move_ok |=> !reg_wr.strobe)
        else $error("refused move still wrote");

    cov_move: cover property (reg_wr.strobe);
    cov_wait_wake: cover property (state_q == ST_WAIT ##1 state_q == ST_WAKE);
    cov_skip_taken: cover property (took && in_fetch2 && is_skip && reached);
    cov_refused: cover property (blocked_d);
    cov_blit_hold: cover property (state_q == ST_WAIT && reached && !blit_ok);
endmodule

// File: rtl/copper_pkg.sv
// shared constants, states and carrier types for the display list coprocessor
package copper_pkg;
    // widths of the memory side
    localparam int ADDR_W = 19;              // byte address inside the low 512K
    localparam int WORD_W = 16;              // one instruction word
    // register offsets on the apb side (byte addresses)
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_LIST = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    // field positions
    localparam int CTRL_RUN_BIT = 0;         // list execution enabled
    localparam int CTRL_DANGER_BIT = 1;      // lets moves reach $10..$1f
    localparam int STAT_BLOCKED_BIT = 0;     // sticky: a move was refused
    localparam int STAT_STATE_LSB = 1;       // one-hot state code
    localparam int KIND_BIT = 0;             // bit 0 of both instruction words
    localparam int BFD_BIT = 15;             // blitter-finished-disable
    // reset values
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] LIST_RESET = 19'h00000;
    // program counter steps
    localparam logic [ADDR_W-1:0] PC_WORD = 19'h00002;
    localparam logic [ADDR_W-1:0] PC_SKIP = 19'h00006;
    // move destination limits, byte addresses
    localparam logic [8:0] REG_DANGER_MIN = 9'h010;
    localparam logic [8:0] REG_SAFE_MIN = 9'h020;

    // sequencer states
    typedef enum logic [4:0] {
        ST_HALT = 5'b00001,
        ST_FETCH1 = 5'b00010,
        ST_FETCH2 = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_WAKE = 5'b10000
    } seq_state_t;

    // beam counters as seen by the compare logic
    typedef struct packed {
        logic [7:0] v;
        logic [7:0] h;
    } beam_t;

    // read request toward the shared memory arbiter
    typedef struct packed {
        logic req;
        logic [ADDR_W-1:0] addr;
    } mem_req_t;

    // write strobe toward the chip register file
    typedef struct packed {
        logic strobe;
        logic [8:0] addr;
        logic [WORD_W-1:0] data;
    } reg_wr_t;
endpackage
